/* logic/fcdma_pkg.sv */
// Constants, types and helper functions of the four-channel DMA controller.
package fcdma_pkg;

	localparam int NUM_CH = 4;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int CNT_W = 24;
	localparam int BUF_BYTES = 16;

	// Operand size codes.
	localparam logic [1:0] SZ_LONG = 2'h0;
	localparam logic [1:0] SZ_BYTE = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	localparam logic [1:0] SZ_LINE = 2'h3;

	// Bus attribute codes.
	localparam logic [1:0] TT_IDLE = 2'h0;
	localparam logic [1:0] TT_DMA = 2'h1;
	localparam logic [1:0] TM_NOACK = 2'h0;
	localparam logic [1:0] TM_CH0 = 2'h1;
	localparam logic [1:0] TM_CH1 = 2'h2;

	// Termination kinds.
	localparam logic [1:0] END_OK = 2'h0;
	localparam logic [1:0] END_BUS = 2'h1;
	localparam logic [1:0] END_CFG = 2'h2;

	// Reset values.
	localparam logic [ADDR_W-1:0] RST_ADDR = 32'h0;
	localparam logic [CNT_W-1:0] RST_COUNT = 24'h0;
	localparam logic [1:0] RST_PIN_SYNC = 2'h3;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_READ = 2'h1,
		ST_WRITE = 2'h3,
		ST_FINISH = 2'h2
	} fcdma_state_t;

	typedef struct packed {
		logic extReqEn;
		logic singleAddressSelect;
		logic ackLastOnly;
		logic continuous;
		logic srcInc;
		logic dstInc;
		logic onChipPeer;
		logic [1:0] srcSize;
		logic [1:0] dstSize;
	} fcdma_cfg_t;

	typedef struct packed {
		logic busy;
		logic done;
		logic busErr;
		logic cfgErr;
		logic [CNT_W-1:0] count;
	} fcdma_stat_t;

	typedef struct packed {
		logic req;
		logic write;
		logic [1:0] size;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} fcdma_bus_t;

	// Bytes in one operand of the given size.
	function automatic logic [4:0] opBytes(input logic [1:0] sz);
		case (sz)
			SZ_BYTE: opBytes = 5'h01;
			SZ_WORD: opBytes = 5'h02;
			SZ_LINE: opBytes = 5'h10;
			default: opBytes = 5'h04;
		endcase
	endfunction

	// Bytes moved by one bus beat; a line goes as longword beats.
	function automatic logic [2:0] beatBytes(input logic [1:0] sz);
		case (sz)
			SZ_BYTE: beatBytes = 3'h1;
			SZ_WORD: beatBytes = 3'h2;
			default: beatBytes = 3'h4;
		endcase
	endfunction

endpackage

/* logic/fcdma_buffer.sv */
// Sixteen-byte staging buffer between the read and write phases.
`timescale 1ns/100ps
module fcdma_buffer
	import fcdma_pkg::*;
(
	input wire logic ref_clk, // Clock.
	input wire logic ce, // Clock enable.
	input wire logic wrEn, // Store one beat.
	input wire logic [3:0] wrOff, // Byte offset of the beat.
	input wire logic [2:0] wrBytes, // Bytes in the beat.
	input wire logic [DATA_W-1:0] wrData, // Beat data, low bytes first.
	input wire logic [3:0] rdOff, // Byte offset to read.
	output logic [DATA_W-1:0] rdData // Four bytes from the offset.
);

	logic [7:0] mem [BUF_BYTES];

	// Stores the valid bytes of a beat; offsets wrap inside the buffer.
	always_ff @(posedge ref_clk) begin
		if (ce && wrEn) begin
			for (int b = 0; b < 4; b++) begin
				if (3'(b) < wrBytes) begin
					mem[4'(wrOff + 4'(b))] <= wrData[8*b +: 8];
				end
			end
		end
	end

	// Gathers four bytes for the write phase.
	for (genvar g = 0; g < 4; g++) begin : g_rd
		assign rdData[8*g +: 8] = mem[4'(rdOff + 4'(g))];
	end

endmodule // fcdma_buffer

/* logic/fcdma_arbiter.sv */
// Round-robin arbiter that grants a channel only at a transfer boundary.
`timescale 1ns/100ps
module fcdma_arbiter
	import fcdma_pkg::*;
(
	input wire logic ref_clk, // Clock.
	input wire logic rstn, // Synchronous reset, active low.
	input wire logic ce, // Clock enable.
	input wire logic [NUM_CH-1:0] want, // Channels asking for service.
	input wire logic boundary, // Engine idle between operands.
	output logic grant, // One-cycle grant strobe.
	output logic [1:0] grantCh // Granted channel.
);

	logic [1:0] last_ff;
	logic found;
	logic [1:0] pick;
	logic [1:0] idx;

	// Searches from the channel after the last winner.
	always_comb begin
		found = 1'b0;
		pick = last_ff;
		idx = last_ff;
		for (int k = 1; k <= NUM_CH; k++) begin
			idx = 2'(last_ff + 2'(k));
			if (!found && want[idx]) begin
				found = 1'b1;
				pick = idx;
			end
		end
	end

	// A grant is only possible while the engine sits at a boundary.
	assign grant = boundary & found;
	assign grantCh = pick;

	// Remembers the winner for fairness.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			last_ff <= 2'h3;
		end else if (ce && grant) begin
			last_ff <= pick;
		end
	end

endmodule // fcdma_arbiter

/* logic/fcdma_top.sv */
// Four-channel DMA controller: request logic, channel state and transfer engine.
`timescale 1ns/100ps
module fcdma_top
	import fcdma_pkg::*;
(
	input wire logic ref_clk, // Clock, 250 MHz.
	input wire logic rstn, // Synchronous reset, active low.
	input wire logic ce, // Clock enable; low freezes all state.
	input wire logic [1:0] extDmaRequestN, // Request pins of channels 0 and 1.
	input wire logic [1:0] pinAssignmentReg, // 1 selects the request function.
	output logic [1:0] parallelPortBit, // Pin level when used as port bit.
	input wire logic [1:0] uartIrq, // Serial-port interrupts for channels 2, 3.
	input wire logic countWidthSelect, // 1 keeps 24 count bits, 0 keeps 16.
	input wire fcdma_cfg_t [NUM_CH-1:0] channelControlReg, // Live control.
	input wire logic [NUM_CH-1:0] startPulse, // Software start strobes.
	input wire logic loadStb, // Load pointers and count.
	input wire logic [1:0] loadChan, // Channel to load.
	input wire logic [ADDR_W-1:0] sourceAddressReg, // Source pointer value.
	input wire logic [ADDR_W-1:0] destinationAddressReg, // Destination value.
	input wire logic [CNT_W-1:0] byteCountReg, // Byte count value.
	input wire logic [NUM_CH-1:0] clrStatus, // Clear done and error flags.
	output fcdma_stat_t [NUM_CH-1:0] chanStatus, // Per-channel status.
	output fcdma_bus_t busOut, // Bus request, address and data.
	input wire logic [DATA_W-1:0] busRdata, // Read data, low bytes first.
	input wire logic busAck, // Beat finished.
	input wire logic busErr, // Beat failed; valid with busAck.
	output logic [1:0] busTransferType, // Transfer type code.
	output logic [2:0] busTransferModifier // Transfer modifier code.
);

	//--------------------------------------------------------------
	// Declarations
	//--------------------------------------------------------------
	logic [1:0] extS1_ff, extS2_ff, extPrev_ff, uartPrev_ff;
	logic [NUM_CH-1:0] reqEdge, hwReq, want, grantOh, finOh;
	logic [NUM_CH-1:0] reqPend_ff, contRun_ff, done_ff, busErrF_ff, cfgErrF_ff;
	logic [NUM_CH-1:0] nxt_reqPend, nxt_contRun, nxt_done, nxt_busErrF, nxt_cfgErrF;
	logic [NUM_CH-1:0] doneSet, busy;
	logic [ADDR_W-1:0] srcAddr_ff [NUM_CH];
	logic [ADDR_W-1:0] dstAddr_ff [NUM_CH];
	logic [CNT_W-1:0] count_ff [NUM_CH];
	fcdma_state_t state_ff, nxt_state;
	fcdma_bus_t bus_ff, nxt_bus;
	logic [1:0] ch_ff, nxt_ch, sSize_ff, nxt_sSize, dSize_ff, nxt_dSize;
	logic [1:0] endKind_ff, nxt_endKind;
	logic single_ff, nxt_single;
	logic [4:0] rdOff_ff, nxt_rdOff, wrOff_ff, nxt_wrOff;
	logic [2:0] attr_ff, nxt_attr, attrNow;
	logic grant, boundary, bufWr, srcAdv, dstAdv, cntDec, isLast;
	logic [1:0] grantCh, tmAck;
	logic [2:0] beatS, beatD;
	logic [4:0] opS, opD, opLen, rdNext, wrNext;
	logic [DATA_W-1:0] bufRd;
	logic [CNT_W-1:0] cntNow, cntAfter, loadCnt;
	fcdma_cfg_t cfgCh;

	//--------------------------------------------------------------
	// Request inputs
	//--------------------------------------------------------------
	// Two-stage synchroniser for the request pins; idle level is high.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			extS1_ff <= RST_PIN_SYNC;
			extS2_ff <= RST_PIN_SYNC;
			extPrev_ff <= RST_PIN_SYNC;
			uartPrev_ff <= 2'h0;
		end else if (ce) begin
			extS1_ff <= extDmaRequestN;
			extS2_ff <= extS1_ff;
			extPrev_ff <= extS2_ff;
			uartPrev_ff <= uartIrq;
		end
	end

	// Falling edge of a request pin asks for one operand; pins held high stay quiet.
	assign reqEdge[1:0] = extPrev_ff & ~extS2_ff & pinAssignmentReg;
	// Channels 2 and 3 are requested by the rising serial-port interrupt.
	assign reqEdge[3:2] = uartIrq & ~uartPrev_ff;
	// A pin given to the parallel port shows its level, otherwise reads high.
	assign parallelPortBit = extS2_ff | pinAssignmentReg;

	// Hardware requests count only where the channel enables them.
	for (genvar g = 0; g < NUM_CH; g++) begin : g_hw
		assign hwReq[g] = reqEdge[g] & channelControlReg[g].extReqEn;
		assign want[g] = (count_ff[g] != RST_COUNT) & (reqPend_ff[g] | contRun_ff[g]);
		assign busy[g] = want[g] | ((state_ff != ST_IDLE) & (ch_ff == 2'(g)));
		assign chanStatus[g] = '{busy[g], done_ff[g], busErrF_ff[g], cfgErrF_ff[g],
			count_ff[g]};
	end

	//--------------------------------------------------------------
	// Arbitration and operand sizing
	//--------------------------------------------------------------
	assign boundary = (state_ff == ST_IDLE);

	fcdma_arbiter u_arb (
		.ref_clk (ref_clk),
		.rstn (rstn),
		.ce (ce),
		.want (want),
		.boundary (boundary),
		.grant (grant),
		.grantCh (grantCh)
	);

	// Operand length is the wider of the two sides, or the source size in single-address mode; each side beats at its own width.
	assign beatS = beatBytes(sSize_ff);
	assign beatD = beatBytes(dSize_ff);
	assign opS = opBytes(sSize_ff);
	assign opD = opBytes(dSize_ff);
	assign opLen = single_ff ? opS : ((opS > opD) ? opS : opD);
	assign rdNext = 5'(rdOff_ff + {2'h0, beatS});
	assign wrNext = 5'(wrOff_ff + {2'h0, beatD});
	assign cfgCh = channelControlReg[ch_ff];
	assign cntNow = count_ff[ch_ff];
	assign isLast = (cntNow <= {19'h0, opLen});

	// Acknowledge code names channel 0 or 1; ack-last-only hides it until the end.
	assign tmAck = (ch_ff == 2'h0) ? TM_CH0 : ((ch_ff == 2'h1) ? TM_CH1 : TM_NOACK);
	assign attrNow = {(cfgCh.ackLastOnly && !isLast) ? TM_NOACK : tmAck,
		single_ff};

	//--------------------------------------------------------------
	// Transfer engine
	//--------------------------------------------------------------
	// Each beat is issued with req high and retired on busAck.
	always_comb begin
		nxt_state = state_ff;
		nxt_bus = bus_ff;
		nxt_ch = ch_ff;
		nxt_sSize = sSize_ff;
		nxt_dSize = dSize_ff;
		nxt_single = single_ff;
		nxt_endKind = endKind_ff;
		nxt_rdOff = rdOff_ff;
		nxt_wrOff = wrOff_ff;
		nxt_attr = attr_ff;
		bufWr = 1'b0;
		srcAdv = 1'b0;
		dstAdv = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				if (grant) begin
					nxt_ch = grantCh;
					nxt_sSize = channelControlReg[grantCh].srcSize;
					nxt_dSize = channelControlReg[grantCh].dstSize;
					nxt_single = channelControlReg[grantCh].singleAddressSelect;
					nxt_rdOff = 5'h0;
					nxt_wrOff = 5'h0;
					nxt_endKind = END_OK;
					nxt_state = ST_READ;
					// On-chip peers cannot take single-address cycles.
					if (channelControlReg[grantCh].singleAddressSelect &&
						channelControlReg[grantCh].onChipPeer) begin
						nxt_endKind = END_CFG;
						nxt_state = ST_FINISH;
					end
				end
			end
			ST_READ: begin
				if (!bus_ff.req) begin
					nxt_bus.req = 1'b1;
					nxt_bus.write = 1'b0;
					nxt_bus.addr = srcAddr_ff[ch_ff];
					nxt_bus.size = sSize_ff;
					nxt_attr = attrNow;
				end else if (busAck) begin
					nxt_bus.req = 1'b0;
					if (busErr) begin
						nxt_endKind = END_BUS;
						nxt_state = ST_FINISH;
					end else begin
						srcAdv = 1'b1;
						bufWr = !single_ff;
						nxt_rdOff = rdNext;
						if (rdNext >= opLen) begin
							nxt_state = single_ff ? ST_FINISH : ST_WRITE;
						end
					end
				end
			end
			ST_WRITE: begin
				if (!bus_ff.req) begin
					nxt_bus.req = 1'b1;
					nxt_bus.write = 1'b1;
					nxt_bus.addr = dstAddr_ff[ch_ff];
					nxt_bus.size = dSize_ff;
					nxt_bus.wdata = bufRd;
					nxt_attr = attrNow;
				end else if (busAck) begin
					nxt_bus.req = 1'b0;
					if (busErr) begin
						nxt_endKind = END_BUS;
						nxt_state = ST_FINISH;
					end else begin
						dstAdv = 1'b1;
						nxt_wrOff = wrNext;
						if (wrNext >= opLen) begin
							nxt_state = ST_FINISH;
						end
					end
				end
			end
			ST_FINISH: begin
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
				nxt_bus.req = 1'b0;
			end
		endcase
	end

	// Engine registers.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state_ff <= ST_IDLE;
			bus_ff <= '0;
			ch_ff <= 2'h0;
			sSize_ff <= SZ_LONG;
			dSize_ff <= SZ_LONG;
			single_ff <= 1'b0;
			endKind_ff <= END_OK;
			rdOff_ff <= 5'h0;
			wrOff_ff <= 5'h0;
			attr_ff <= 3'h0;
		end else if (ce) begin
			state_ff <= nxt_state;
			bus_ff <= nxt_bus;
			ch_ff <= nxt_ch;
			sSize_ff <= nxt_sSize;
			dSize_ff <= nxt_dSize;
			single_ff <= nxt_single;
			endKind_ff <= nxt_endKind;
			rdOff_ff <= nxt_rdOff;
			wrOff_ff <= nxt_wrOff;
			attr_ff <= nxt_attr;
		end
	end

	fcdma_buffer u_buf (
		.ref_clk (ref_clk),
		.ce (ce),
		.wrEn (bufWr),
		.wrOff (rdOff_ff[3:0]),
		.wrBytes (beatS),
		.wrData (busRdata),
		.rdOff (wrOff_ff[3:0]),
		.rdData (bufRd)
	);

	// Bus outputs; the type code marks every cycle the engine drives.
	assign busOut = bus_ff;
	assign busTransferType = bus_ff.req ? TT_DMA : TT_IDLE;
	assign busTransferModifier = bus_ff.req ? attr_ff : 3'h0;

	//--------------------------------------------------------------
	// Channel termination and flags
	//--------------------------------------------------------------
	assign finOh = (state_ff == ST_FINISH) ? (4'h1 << ch_ff) : 4'h0;
	assign grantOh = grant ? (4'h1 << grantCh) : 4'h0;
	assign cntDec = (state_ff == ST_FINISH) & (endKind_ff == END_OK);
	assign cntAfter = isLast ? RST_COUNT : CNT_W'(cntNow - {19'h0, opLen});
	// Count zero or any error ends the channel and marks it done.
	assign doneSet = finOh & {NUM_CH{(endKind_ff != END_OK) | (cntAfter == RST_COUNT)}};
	// Set wins over a clear arriving in the same cycle.
	assign nxt_done = (done_ff & ~clrStatus) | doneSet;
	assign nxt_busErrF = (busErrF_ff & ~clrStatus) | (finOh & {NUM_CH{endKind_ff == END_BUS}});
	assign nxt_cfgErrF = (cfgErrF_ff & ~clrStatus) | (finOh & {NUM_CH{endKind_ff == END_CFG}});
	// Each operand consumes the pending request; a new request arriving in the finish cycle is kept.
	assign nxt_reqPend = (reqPend_ff & ~finOh) | startPulse | hwReq;
	// Continuous channels keep running from their grant until done.
	assign nxt_contRun = (contRun_ff & ~doneSet) | (grantOh & {
		channelControlReg[3].continuous, channelControlReg[2].continuous,
		channelControlReg[1].continuous, channelControlReg[0].continuous});
	assign loadCnt = countWidthSelect ? byteCountReg : {8'h0, byteCountReg[15:0]};

	// Flag registers.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			reqPend_ff <= 4'h0;
			contRun_ff <= 4'h0;
			done_ff <= 4'h0;
			busErrF_ff <= 4'h0;
			cfgErrF_ff <= 4'h0;
		end else if (ce) begin
			reqPend_ff <= nxt_reqPend;
			contRun_ff <= nxt_contRun;
			done_ff <= nxt_done;
			busErrF_ff <= nxt_busErrF;
			cfgErrF_ff <= nxt_cfgErrF;
		end
	end

	// Per-channel pointers and count; a software load wins over engine updates.
	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < NUM_CH; i++) begin
			if (!rstn) begin
				srcAddr_ff[i] <= RST_ADDR;
				dstAddr_ff[i] <= RST_ADDR;
				count_ff[i] <= RST_COUNT;
			end else if (ce && loadStb && loadChan == 2'(i)) begin
				srcAddr_ff[i] <= sourceAddressReg;
				dstAddr_ff[i] <= destinationAddressReg;
				count_ff[i] <= loadCnt;
			end else if (ce && ch_ff == 2'(i)) begin
				if (srcAdv && cfgCh.srcInc) begin
					srcAddr_ff[i] <= ADDR_W'(srcAddr_ff[i] + {29'h0, beatS});
				end
				if (dstAdv && cfgCh.dstInc) begin
					dstAddr_ff[i] <= ADDR_W'(dstAddr_ff[i] + {29'h0, beatD});
				end
				if (cntDec) begin
					count_ff[i] <= cntAfter;
				end
			end
		end
	end

endmodule // fcdma_top

/* testbench/fcdma_top_assertions.sv */
// Concurrent checks on the ports of the DMA controller top module.
`timescale 1ns/100ps
module fcdma_top_assertions
	import fcdma_pkg::*;
(
	input wire logic ref_clk, // Clock.
	input wire logic rstn, // Reset, active low.
	input wire logic ce, // Clock enable.
	input wire logic [1:0] pinAssignmentReg, // Pin function select.
	input wire logic [1:0] parallelPortBit, // Port bit levels.
	input wire logic countWidthSelect, // Count width select.
	input wire fcdma_cfg_t [NUM_CH-1:0] channelControlReg, // Channel control.
	input wire logic [NUM_CH-1:0] startPulse, // Start strobes.
	input wire logic loadStb, // Load strobe.
	input wire logic [1:0] loadChan, // Channel loaded.
	input wire logic [CNT_W-1:0] byteCountReg, // Count loaded.
	input wire fcdma_stat_t [NUM_CH-1:0] chanStatus, // Channel status.
	input wire fcdma_bus_t busOut, // Bus request.
	input wire logic busAck, // Beat finished.
	input wire logic [1:0] busTransferType, // Transfer type.
	input wire logic [2:0] busTransferModifier // Transfer modifier.
);
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	logic ldSeen_ff;
	logic [1:0] ldCh_ff;
	logic [CNT_W-1:0] ldVal_ff;
	wire logic [CNT_W-1:0] nxt_ldVal = countWidthSelect ? byteCountReg : {8'h0, byteCountReg[15:0]};
	wire logic allIdle = !busOut.req && !chanStatus[0].busy && !chanStatus[1].busy
		&& !chanStatus[2].busy && !chanStatus[3].busy;
	wire logic ch0Ok = !(channelControlReg[0].singleAddressSelect && channelControlReg[0].onChipPeer);

	// Remembers the last load so the reported count can be compared one cycle later.
	always_ff @(posedge ref_clk) begin
		ldSeen_ff <= rstn && loadStb && ce;
		ldCh_ff <= loadChan;
		ldVal_ff <= nxt_ldVal;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_type_marks_dma: assert property (busTransferType == (busOut.req ? TT_DMA : TT_IDLE))
		else $error("transfer type does not follow the bus request");
	a_idle_no_attr: assert property (!busOut.req |-> busTransferModifier == 3'h0)
		else $error("modifier not zero outside DMA cycles");
	a_tm_not_reserved: assert property (busOut.req |-> busTransferModifier[2:1] != 2'h3)
		else $error("reserved acknowledge code driven");
	a_beat_holds_attr: assert property (busOut.req && !busAck |=> busOut.req
		&& $stable(busOut.addr) && $stable(busOut.size) && $stable(busOut.write))
		else $error("beat changed before its acknowledge");
	a_ack_ends_beat: assert property (busOut.req && busAck |=> !busOut.req)
		else $error("request held after acknowledge");
	a_single_no_write: assert property (busOut.req && busTransferModifier[0] |-> !busOut.write)
		else $error("single-address beat drove write data");
	a_start_to_bus: assert property (startPulse[0] && ce && allIdle && ch0Ok
		&& chanStatus[0].count != 24'h0 |-> ##[2:4] busOut.req)
		else $error("software start did not reach the bus");
	a_load_sets_count: assert property (ldSeen_ff |-> chanStatus[ldCh_ff].count == ldVal_ff)
		else $error("loaded count not reported");
	a_zero_count_done: assert property ($past(chanStatus[1].count) != 24'h0
		&& chanStatus[1].count == 24'h0 && !$past(loadStb) |-> chanStatus[1].done)
		else $error("count ran out without completion flag");
	a_port_reads_high: assert property (pinAssignmentReg == 2'h3
		&& $past(pinAssignmentReg) == 2'h3 |-> parallelPortBit == 2'h3)
		else $error("request pin seen as port bit");
endmodule // fcdma_top_assertions

bind fcdma_top fcdma_top_assertions i_chk (.ref_clk(ref_clk), .rstn(rstn), .ce(ce),
	.pinAssignmentReg(pinAssignmentReg), .parallelPortBit(parallelPortBit),
	.countWidthSelect(countWidthSelect), .channelControlReg(channelControlReg),
	.startPulse(startPulse), .loadStb(loadStb), .loadChan(loadChan),
	.byteCountReg(byteCountReg), .chanStatus(chanStatus), .busOut(busOut), .busAck(busAck),
	.busTransferType(busTransferType), .busTransferModifier(busTransferModifier));

/* testbench/fcdma_mem_model.sv */
// Behavioural memory and peripheral that answers the controller's bus beats.
`timescale 1ns/100ps
module fcdma_mem_model
	import fcdma_pkg::*;
(
	input wire logic ref_clk, // Clock.
	input wire logic rstn, // Reset, active low.
	input wire fcdma_bus_t busOut, // Bus request from the controller.
	input wire logic slow, // Adds three wait states to every beat.
	input wire logic errNext, // Answers beats with an error.
	output logic [DATA_W-1:0] busRdata, // Read data, low bytes first.
	output logic busAck, // Beat finished.
	output logic busErr // Error flag, valid with busAck.
);
	logic [1:0] waitCnt_ff;
	logic [DATA_W-1:0] memWord;

	// Each byte holds its own address folded with a constant pattern.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			memWord[8*i +: 8] = (busOut.addr[7:0] + 8'(i)) ^ 8'ha5;
		end
	end

	// Acknowledges one beat at a time; idle lines toggle so stale data is never reused.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			busAck <= 1'b0;
			busErr <= 1'b0;
			busRdata <= 32'h0;
			waitCnt_ff <= 2'h0;
		end else if (busOut.req && !busAck && waitCnt_ff == (slow ? 2'h3 : 2'h0)) begin
			busAck <= 1'b1;
			busErr <= errNext;
			busRdata <= busOut.write ? ~busRdata : memWord;
			waitCnt_ff <= 2'h0;
		end else begin
			busAck <= 1'b0;
			busErr <= ~busErr;
			busRdata <= ~busRdata;
			waitCnt_ff <= (busOut.req && !busAck) ? waitCnt_ff + 2'h1 : 2'h0;
		end
	end
endmodule // fcdma_mem_model

/* testbench/test_four_channel_dma_controller.sv */
// Self-checking testbench of the four-channel DMA controller.
`timescale 1ns/100ps
module test_four_channel_dma_controller
	import fcdma_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic ce = 1'b1;
	logic [1:0] extDmaRequestN = 2'h3;
	logic [1:0] pinAssignmentReg = 2'h3;
	logic [1:0] parallelPortBit;
	logic [1:0] uartIrq = 2'h0;
	logic countWidthSelect = 1'b1;
	fcdma_cfg_t [NUM_CH-1:0] channelControlReg = '0;
	logic [NUM_CH-1:0] startPulse = 4'h0;
	logic [NUM_CH-1:0] clrStatus = 4'h0;
	logic loadStb = 1'b0;
	logic [1:0] loadChan = 2'h0;
	logic [ADDR_W-1:0] sourceAddressReg = 32'h0;
	logic [ADDR_W-1:0] destinationAddressReg = 32'h0;
	logic [CNT_W-1:0] byteCountReg = 24'h0;
	fcdma_stat_t [NUM_CH-1:0] chanStatus;
	fcdma_bus_t busOut;
	logic [DATA_W-1:0] busRdata;
	logic busAck, busErr, slow = 1'b0, errNext = 1'b0;
	logic [1:0] busTransferType;
	logic [2:0] busTransferModifier, lastTm;
	logic [31:0] wAddr, wData;
	int mismatches = 0, checks_done = 0, beats = 0, writes = 0, ackBeats = 0, saBeats = 0;

	always #2 ref_clk = ~ref_clk;

	fcdma_top i_dut (.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .extDmaRequestN(extDmaRequestN),
		.pinAssignmentReg(pinAssignmentReg), .parallelPortBit(parallelPortBit),
		.uartIrq(uartIrq), .countWidthSelect(countWidthSelect),
		.channelControlReg(channelControlReg), .startPulse(startPulse), .loadStb(loadStb),
		.loadChan(loadChan), .sourceAddressReg(sourceAddressReg),
		.destinationAddressReg(destinationAddressReg), .byteCountReg(byteCountReg),
		.clrStatus(clrStatus), .chanStatus(chanStatus), .busOut(busOut), .busRdata(busRdata),
		.busAck(busAck), .busErr(busErr), .busTransferType(busTransferType),
		.busTransferModifier(busTransferModifier));

	fcdma_mem_model i_mem (.ref_clk(ref_clk), .rstn(rstn), .busOut(busOut), .slow(slow),
		.errNext(errNext), .busRdata(busRdata), .busAck(busAck), .busErr(busErr));

	// Tallies finished beats and keeps the attributes of the last one.
	always @(posedge ref_clk) begin
		if (busOut.req === 1'b1 && busAck === 1'b1) begin
			beats = beats + 1;
			lastTm = busTransferModifier;
			if (busTransferModifier[2:1] !== 2'h0) ackBeats = ackBeats + 1;
			if (busTransferModifier[0] === 1'b1) saBeats = saBeats + 1;
			if (busOut.write === 1'b1) begin
				writes = writes + 1;
				wAddr = busOut.addr;
				wData = busOut.wdata;
			end
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task tick; @(posedge ref_clk); #1; endtask
	task chk(input logic ok, input string what);
		checks_done++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("MISMATCH at %0t: %s", $time, what);
		end
	endtask
	function fcdma_cfg_t cfg(input logic e, s, a, c, o, input logic [1:0] ss, ds);
		cfg = {e, s, a, c, 1'b1, 1'b1, o, ss, ds};
	endfunction
	task ld(input int ch, input logic [31:0] s, d, input logic [23:0] n);
		{beats, writes, ackBeats, saBeats} = '0;
		{loadStb, loadChan, sourceAddressReg, destinationAddressReg, byteCountReg} = {1'b1, 2'(ch), s, d, n};
		tick;
		loadStb = 1'b0;
	endtask
	task go(input int ch); startPulse[ch] = 1'b1; tick; startPulse = 4'h0; endtask
	task pinReq; extDmaRequestN[0] = 1'b0; repeat (3) tick; extDmaRequestN[0] = 1'b1; endtask
	task waitDone(input int ch);
		for (int k = 0; k < 400 && chanStatus[ch].done !== 1'b1; k++) tick;
		chk(chanStatus[ch].done === 1'b1, "channel never completed");
	endtask
	task clr(input int ch); clrStatus[ch] = 1'b1; tick; clrStatus = 4'h0; tick; endtask
	task end_sim;
		if (mismatches == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task countWidth;
		countWidthSelect = 1'b0;
		ld(1, 32'h0, 32'h0, 24'h123456);
		chk(chanStatus[1].count === 24'h003456, "short count width");
		countWidthSelect = 1'b1;
		ld(1, 32'h0, 32'h0, 24'h123456);
		chk(chanStatus[1].count === 24'h123456, "full count width");
	endtask
	task dualByte;
		channelControlReg[0] = cfg(0, 0, 0, 0, 0, SZ_BYTE, SZ_BYTE);
		ld(0, 32'h10000010, 32'h20000000, 24'h1);
		go(0);
		chk(chanStatus[0].busy === 1'b1, "busy after start");
		waitDone(0);
		chk(beats == 2 && writes == 1 && wAddr === 32'h20000000, "read then write");
		chk(wData[7:0] === 8'hb5 && chanStatus[0].count === 24'h0, "byte moved");
		chk(lastTm === 3'h2 && ackBeats == 2, "channel 0 code on every beat");
		clr(0);
	endtask
	task contLong;
		channelControlReg[1] = cfg(0, 0, 1, 1, 0, SZ_LONG, SZ_LONG);
		ld(1, 32'h10000100, 32'h20000100, 24'h8);
		go(1);
		waitDone(1);
		chk(beats == 4 && writes == 2, "continuous ran to zero");
		chk(ackBeats == 2 && lastTm === 3'h4, "code on last operand only");
		chk(wData === 32'ha2a3a0a1, "longword data");
		clr(1);
	endtask
	task singlePin;
		pinAssignmentReg[1] = 1'b0;
		extDmaRequestN[1] = 1'b0;
		repeat (4) tick;
		chk(parallelPortBit[1] === 1'b0, "port bit level");
		extDmaRequestN[1] = 1'b1;
		repeat (4) tick;
		pinAssignmentReg[1] = 1'b1;
		channelControlReg[0] = cfg(1, 1, 0, 0, 0, SZ_WORD, SZ_WORD);
		ld(0, 32'h30000000, 32'h0, 24'h4);
		pinReq;
		for (int k = 0; k < 200 && chanStatus[0].count !== 24'h2; k++) tick;
		chk(beats == 1 && writes == 0 && saBeats == 1, "single read beat");
		chk(chanStatus[0].count === 24'h2 && chanStatus[0].done === 1'b0, "one per request");
		pinReq;
		waitDone(0);
		chk(beats == 2 && lastTm === 3'h3, "single flag beside channel code");
		clr(0);
	endtask
	task uartChan;
		channelControlReg[2] = cfg(1, 0, 0, 0, 1, SZ_LONG, SZ_LONG);
		ld(2, 32'h10000200, 32'h20000200, 24'h4);
		uartIrq[0] = 1'b1;
		repeat (2) tick;
		uartIrq[0] = 1'b0;
		waitDone(2);
		chk(beats == 2 && ackBeats == 0 && lastTm === 3'h0, "no code for channel 2");
		clr(2);
	endtask
	task errors;
		channelControlReg[3] = cfg(0, 0, 0, 0, 0, SZ_LONG, SZ_LONG);
		ld(3, 32'h10000300, 32'h20000300, 24'h4);
		errNext = 1'b1;
		go(3);
		waitDone(3);
		errNext = 1'b0;
		chk(chanStatus[3].busErr === 1'b1 && chanStatus[3].count === 24'h4, "bus error");
		chk(beats == 1, "aborted after failed beat");
		clr(3);
		chk(chanStatus[3].done === 1'b0 && chanStatus[3].busErr === 1'b0, "status cleared");
		channelControlReg[3] = cfg(0, 1, 0, 0, 1, SZ_LONG, SZ_LONG);
		ld(3, 32'h10000300, 32'h20000300, 24'h4);
		go(3);
		waitDone(3);
		chk(chanStatus[3].cfgErr === 1'b1 && beats == 0, "single refused on chip");
		clr(3);
	endtask
	task lineToBytes;
		slow = 1'b1;
		channelControlReg[0] = cfg(0, 0, 0, 0, 0, SZ_LINE, SZ_BYTE);
		ld(0, 32'h10000300, 32'h20000300, 24'h10);
		go(0);
		waitDone(0);
		chk(beats == 20 && writes == 16, "line split into beats");
		chk(wAddr === 32'h2000030f && wData[7:0] === 8'haa, "last byte of line");
		slow = 1'b0;
		clr(0);
	endtask

	// Reset, then the scenarios in turn.
	initial begin
		repeat (20) @(posedge ref_clk);
		#1 rstn = 1'b1;
		tick;
		countWidth;
		dualByte;
		contLong;
		singlePin;
		uartChan;
		errors;
		lineToBytes;
		end_sim;
	end

	// Cuts a hang short well after the scenarios should have finished.
	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		end_sim;
	end
endmodule // test_four_channel_dma_controller
